/* File: hdl/pmu_cfg_params.svh */
// offsets, field positions, reset values and timing constants of the bank
`ifndef PMU_CFG_PARAMS_SVH
`define PMU_CFG_PARAMS_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define OFS_DEVICE_CONTROL_TWO    8'h25
`define OFS_SERIAL_PORT_CONFIG    8'h26
`define OFS_SLEEP_KEEP_ACTIVE_ONE 8'h27
`define OFS_SLEEP_KEEP_ACTIVE_TWO 8'h28

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define BIT_SLEEP_UNMASK       7
`define BIT_IRQ_PUSH_PULL      6
`define BIT_SLOT_HI            5
`define BIT_SLOT_LO            4
`define BIT_SLEEP_POLARITY     3
`define BIT_LP_SHUTDOWN        2
`define BIT_LP_SHUTDOWN_RELOAD 1
`define BIT_IRQ_POLARITY       0
`define BIT_SCALING_ADDR_HI    7
`define BIT_SCALING_ADDR_LO    6
`define BIT_GENERAL_ADDR_HI    5
`define BIT_GENERAL_ADDR_LO    4

// ------------------------------------------------------------------
// writable masks and reset values
// ------------------------------------------------------------------
`define WMASK_DEVICE_CONTROL_TWO 8'hff
`define WMASK_SERIAL_PORT_CONFIG 8'h0f
`define WMASK_KEEP_ACTIVE_ONE    8'hff
`define WMASK_KEEP_ACTIVE_TWO    8'h3f
`define DEFAULT_FORCE_ZERO_DCT   8'h77
`define RESET_BYTE               8'h00
`define UNMAPPED_READ            8'h00

// ------------------------------------------------------------------
// target address bases
// ------------------------------------------------------------------
`define SCALING_ADDR_BASE 7'h12
`define GENERAL_ADDR_BASE 7'h2d

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define CLK_PERIOD_NS   4
`define SLOT0_TIME_US   30
`define SLOT1_TIME_US   200
`define SLOT2_TIME_US   500
`define SLOT3_TIME_MS   2
`define SLOT0_CYCLES    ((`SLOT0_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SLOT1_CYCLES    ((`SLOT1_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SLOT2_CYCLES    ((`SLOT2_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SLOT3_CYCLES    ((`SLOT3_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define LP_WARN_TIME_S  4
`define LP_EXTRA_TIME_S 1
`define CYCLES_PER_S    (1000000000 / `CLK_PERIOD_NS)
`define LP_WARN_CYCLES  (`LP_WARN_TIME_S * `CYCLES_PER_S)
`define LP_EXTRA_CYCLES (`LP_EXTRA_TIME_S * `CYCLES_PER_S)

`endif

/* File: hdl/pmu_cfg_pkg.sv */
// types shared by the configuration register bank
package pmu_cfg_pkg;

  // register access from the serial port front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // read answer
  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } reg_rsp_t;

  // default contents held in one-time-programmable memory
  typedef struct packed {
    logic [7:0] device_control_two;
    logic [7:0] serial_port_config;
    logic [7:0] sleep_keep_active_one;
    logic [7:0] sleep_keep_active_two;
  } otp_defaults_t;

  // one pad: level and enable (enable low while driving)
  typedef struct packed {
    logic out;
    logic oe_n;
  } pad_t;

  // sleep-state regulation choice for every regulator
  typedef struct packed {
    logic [9:0] regulator_sleep_active;
    logic [3:0] buck_sleep_active;
    logic [3:0] buck_sleep_low_power;
  } sleep_plan_t;

  typedef enum logic [1:0] {
    LP_IDLE,
    LP_WARNED,
    LP_DONE
  } lp_state_t;

endpackage : pmu_cfg_pkg

/* File: hdl/long_press_timer.sv */
// power button long-press timer: warning, then shutdown
`timescale 1ns/100ps
`include "pmu_cfg_params.svh"
module long_press_timer #(
  parameter logic [31:0] WARN_CYCLES  = 32'(`LP_WARN_CYCLES),
  parameter logic [31:0] EXTRA_CYCLES = 32'(`LP_EXTRA_CYCLES)
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic power_button_n,
  output logic      warn_pulse,
  output logic      off_pulse
);
  import pmu_cfg_pkg::*;

  lp_state_t   state_r;
  lp_state_t   state_nxt;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic        pressed;
  logic        warn_hit;
  logic        off_hit;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  assign pressed  = enable & ~power_button_n;
  assign warn_hit = (state_r == LP_IDLE) && (count_r == WARN_CYCLES - 1);
  assign off_hit  = (state_r == LP_WARNED) && (count_r == EXTRA_CYCLES - 1);

  // held low 4 s gives the warning, one more second the off
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r + 32'd1;
    case (state_r)
      LP_IDLE: begin
        if (warn_hit) begin
          state_nxt = LP_WARNED;
          count_nxt = 32'd0;
        end
      end
      LP_WARNED: begin
        if (off_hit) begin
          state_nxt = LP_DONE;
          count_nxt = 32'd0;
        end
      end
      LP_DONE: count_nxt = 32'd0; // one shutdown per press
      default: state_nxt = LP_IDLE;
    endcase
    if (!pressed) begin
      state_nxt = LP_IDLE;
      count_nxt = 32'd0;
    end
  end

  // state and pulses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= LP_IDLE;
      count_r    <= 32'd0;
      warn_pulse <= 1'b0;
      off_pulse  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      count_r    <= count_nxt;
      warn_pulse <= pressed & warn_hit;
      off_pulse  <= pressed & off_hit;
    end
  end

endmodule : long_press_timer

/* File: hdl/pmu_device_config_regs.sv */
// configuration register bank of the power management unit
`timescale 1ns/100ps
`include "pmu_cfg_params.svh"
module pmu_device_config_regs #(
  parameter logic [31:0] SLOT0_CYCLES    = 32'(`SLOT0_CYCLES),
  parameter logic [31:0] SLOT1_CYCLES    = 32'(`SLOT1_CYCLES),
  parameter logic [31:0] SLOT2_CYCLES    = 32'(`SLOT2_CYCLES),
  parameter logic [31:0] SLOT3_CYCLES    = 32'(`SLOT3_CYCLES),
  parameter logic [31:0] LP_WARN_CYCLES  = 32'(`LP_WARN_CYCLES),
  parameter logic [31:0] LP_EXTRA_CYCLES = 32'(`LP_EXTRA_CYCLES)
) (
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire pmu_cfg_pkg::reg_req_t      reg_req,
  output pmu_cfg_pkg::reg_rsp_t           reg_rsp,
  input  wire pmu_cfg_pkg::otp_defaults_t otp_defaults,
  input  wire logic                       sleep_pin,
  input  wire logic                       irq_pending,
  input  wire logic                       irq_request,
  input  wire logic                       power_button_n,
  input  wire logic                       off_state_entry,
  input  wire logic                       keep_contents_in_off_n,
  input  wire logic [3:0]                 buck_forced_mode,
  output logic                            sleep_request,
  output pmu_cfg_pkg::pad_t               irq_out_pin,
  output logic [1:0]                      sequence_slot_duration,
  output logic                            slot_tick,
  output logic                            long_press_irq,
  output logic                            power_off_request,
  output logic                            defaults_reloaded,
  output logic [6:0]                      scaling_port_addr,
  output logic [6:0]                      general_port_addr,
  output logic [3:0]                      buck_port_select,
  output pmu_cfg_pkg::sleep_plan_t        sleep_plan
);
  import pmu_cfg_pkg::*;

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------

  // masked byte update: bits outside the mask keep their value
  function automatic logic [7:0] merge_bits(input logic [7:0] old_val,
                                            input logic [7:0] new_val,
                                            input logic [7:0] mask);
    merge_bits = (old_val & ~mask) | (new_val & mask);
  endfunction : merge_bits

  // two-bit code added onto an address base
  function automatic logic [6:0] addr_of(input logic [6:0] base,
                                         input logic [1:0] code);
    addr_of = base + {5'd0, code};
  endfunction : addr_of

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  // async assert, two-flop release so no flop sees a runt release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  logic [7:0] dev_ctrl_two_r;
  logic [7:0] serial_cfg_r;
  logic [7:0] keep_one_r;
  logic [7:0] keep_two_r;
  logic       load_pend_r;
  logic [7:0] dev_ctrl_two_nxt;
  logic [7:0] serial_cfg_nxt;
  logic [7:0] keep_one_nxt;
  logic [7:0] keep_two_nxt;

  // address decode
  logic hit_dct;
  logic hit_spc;
  logic hit_ka1;
  logic hit_ka2;
  logic wr_dct;
  logic wr_spc;
  logic wr_ka1;
  logic wr_ka2;

  assign hit_dct = (reg_req.addr == `OFS_DEVICE_CONTROL_TWO);
  assign hit_spc = (reg_req.addr == `OFS_SERIAL_PORT_CONFIG);
  assign hit_ka1 = (reg_req.addr == `OFS_SLEEP_KEEP_ACTIVE_ONE);
  assign hit_ka2 = (reg_req.addr == `OFS_SLEEP_KEEP_ACTIVE_TWO);
  assign wr_dct  = reg_req.wr & hit_dct;
  assign wr_spc  = reg_req.wr & hit_spc;
  assign wr_ka1  = reg_req.wr & hit_ka1;
  assign wr_ka2  = reg_req.wr & hit_ka2;

  // field views of the stored bytes
  logic       sleep_unmask;
  logic       irq_push_pull;
  logic [1:0] slot_sel;
  logic       sleep_input_polarity;
  logic       lp_plain_en;
  logic       lp_reload_en;
  logic       irq_pol;

  assign sleep_unmask  = dev_ctrl_two_r[`BIT_SLEEP_UNMASK];
  assign irq_push_pull = dev_ctrl_two_r[`BIT_IRQ_PUSH_PULL];
  assign slot_sel      = dev_ctrl_two_r[`BIT_SLOT_HI:`BIT_SLOT_LO];
  assign sleep_input_polarity     = dev_ctrl_two_r[`BIT_SLEEP_POLARITY];
  assign lp_plain_en   = dev_ctrl_two_r[`BIT_LP_SHUTDOWN];
  assign lp_reload_en  = dev_ctrl_two_r[`BIT_LP_SHUTDOWN_RELOAD];
  assign irq_pol       = dev_ctrl_two_r[`BIT_IRQ_POLARITY];

  // ------------------------------------------------------------------
  // long press and reload of defaults
  // ------------------------------------------------------------------
  logic lp_warn;
  logic lp_off;
  logic lp_reload;
  logic off_reload;
  logic reload_now;
  logic lp_armed;

  // either long-press bit arms the timer
  assign lp_armed = lp_plain_en | lp_reload_en;

  // a released button restarts the count from zero
  long_press_timer #(
    .WARN_CYCLES  (LP_WARN_CYCLES),
    .EXTRA_CYCLES (LP_EXTRA_CYCLES)
  ) u_long_press (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .enable         (lp_armed),
    .power_button_n (power_button_n),
    .warn_pulse     (lp_warn),
    .off_pulse      (lp_off)
  );

  // reload variant wins over plain and over keep-contents
  assign lp_reload  = lp_off & (lp_reload_en | ~keep_contents_in_off_n);
  // other off entries reload only when keep_contents_in_off_n is low
  assign off_reload = off_state_entry & ~keep_contents_in_off_n;
  // first cycle after reset release also loads defaults
  assign reload_now = load_pend_r | lp_reload | off_reload;

  // ------------------------------------------------------------------
  // next register values
  // ------------------------------------------------------------------

  // defaults win over a write in the same cycle; sleep bits default 0
  always_comb begin
    dev_ctrl_two_nxt = dev_ctrl_two_r;
    serial_cfg_nxt   = serial_cfg_r;
    keep_one_nxt     = keep_one_r;
    keep_two_nxt     = keep_two_r;
    if (reload_now) begin
      dev_ctrl_two_nxt = otp_defaults.device_control_two
                         & `DEFAULT_FORCE_ZERO_DCT;
      serial_cfg_nxt   = otp_defaults.serial_port_config;
      keep_one_nxt     = otp_defaults.sleep_keep_active_one;
      keep_two_nxt     = otp_defaults.sleep_keep_active_two
                         & `WMASK_KEEP_ACTIVE_TWO;
    end else begin
      if (wr_dct) begin
        dev_ctrl_two_nxt = merge_bits(dev_ctrl_two_r, reg_req.wdata,
                                      `WMASK_DEVICE_CONTROL_TWO);
      end
      if (wr_spc) begin
        // address selects are read-only
        serial_cfg_nxt = merge_bits(serial_cfg_r, reg_req.wdata,
                                    `WMASK_SERIAL_PORT_CONFIG);
      end
      if (wr_ka1) begin
        keep_one_nxt = merge_bits(keep_one_r, reg_req.wdata,
                                  `WMASK_KEEP_ACTIVE_ONE);
      end
      if (wr_ka2) begin
        // reserved top bits stay zero
        keep_two_nxt = merge_bits(keep_two_r, reg_req.wdata,
                                  `WMASK_KEEP_ACTIVE_TWO);
      end
    end
  end

  // register bytes; power-on reset clears, defaults follow
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_ctrl_two_r <= `RESET_BYTE;
      serial_cfg_r   <= `RESET_BYTE;
      keep_one_r     <= `RESET_BYTE;
      keep_two_r     <= `RESET_BYTE;
      load_pend_r    <= 1'b1;
    end else begin
      dev_ctrl_two_r <= dev_ctrl_two_nxt;
      serial_cfg_r   <= serial_cfg_nxt;
      keep_one_r     <= keep_one_nxt;
      keep_two_r     <= keep_two_nxt;
      load_pend_r    <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  logic [7:0] rdata_sel;
  logic [7:0] rsp_data_w;

  // unmapped offsets read zero
  assign rdata_sel = hit_dct ? dev_ctrl_two_r :
                     hit_spc ? serial_cfg_r :
                     hit_ka1 ? keep_one_r :
                     hit_ka2 ? (keep_two_r & `WMASK_KEEP_ACTIVE_TWO) :
                     `UNMAPPED_READ;

  // idle cycles answer zero, never stale data
  assign rsp_data_w = reg_req.rd ? rdata_sel : `UNMAPPED_READ;

  // answer one cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.valid <= reg_req.rd;
      reg_rsp.rdata <= rsp_data_w;
    end
  end

  // ------------------------------------------------------------------
  // sleep request and interrupt pad
  // ------------------------------------------------------------------
  logic sleep_active;
  logic sleep_go;
  logic irq_level;
  logic pad_drive;

  // polarity 0: high is active, 1: low is active
  assign sleep_active = sleep_pin ^ sleep_input_polarity;
  // pad level follows the programmed polarity
  assign irq_level    = irq_pol ? irq_request : ~irq_request;

  // unmask bit gates it; a pending interrupt holds sleep off
  assign sleep_go     = sleep_unmask & ~irq_pending & sleep_active;
  // open drain only pulls low; push-pull always drives
  assign pad_drive    = irq_push_pull | ~irq_level;

  // a grounded strap with unmask set and low-active polarity would sleep at once: software's job
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_request   <= 1'b0;
      irq_out_pin.out <= 1'b0;
      irq_out_pin.oe_n <= 1'b1;
    end else begin
      sleep_request <= sleep_go;
      irq_out_pin.out <= irq_level;
      irq_out_pin.oe_n <= ~pad_drive;
    end
  end

  // ------------------------------------------------------------------
  // sequencing time slot
  // ------------------------------------------------------------------
  logic [31:0] slot_cnt_r;
  logic [31:0] slot_limit;
  logic        slot_end;
  logic [31:0] slot_cnt_nxt;

  // slot length by code: 30 us, 200 us, 500 us, 2 ms
  assign slot_limit = (slot_sel == 2'b00) ? SLOT0_CYCLES :
                      (slot_sel == 2'b01) ? SLOT1_CYCLES :
                      (slot_sel == 2'b10) ? SLOT2_CYCLES : SLOT3_CYCLES;
  assign slot_end   = (slot_cnt_r >= slot_limit - 32'd1);

  // wrap at the slot end, else count on
  assign slot_cnt_nxt = slot_end ? 32'd0 : slot_cnt_r + 32'd1;

  // free-running slot tick; a shortened limit ends the slot at once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt_r <= 32'd0;
      slot_tick  <= 1'b0;
    end else begin
      slot_cnt_r <= slot_cnt_nxt;
      slot_tick  <= slot_end;
    end
  end

  // ------------------------------------------------------------------
  // configuration outputs
  // ------------------------------------------------------------------
  logic [6:0] scaling_addr_w;
  logic [6:0] general_addr_w;
  logic [9:0] reg_keep_w;
  logic [3:0] buck_keep_w;
  logic [3:0] buck_low_w;

  assign scaling_addr_w = addr_of(`SCALING_ADDR_BASE,
    serial_cfg_r[`BIT_SCALING_ADDR_HI:`BIT_SCALING_ADDR_LO]);
  assign general_addr_w = addr_of(`GENERAL_ADDR_BASE,
    serial_cfg_r[`BIT_GENERAL_ADDR_HI:`BIT_GENERAL_ADDR_LO]);

  // regulators 1..8 then 9, 10
  assign reg_keep_w  = {keep_two_r[1:0], keep_one_r};
  // bucks 1..4 sit in bits 2..5
  assign buck_keep_w = keep_two_r[5:2];
  // forced mode overrides low-power regulation in sleep
  assign buck_low_w  = ~buck_keep_w & ~buck_forced_mode;

  // registered copies keep every output straight from a flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sequence_slot_duration <= 2'b00;
      long_press_irq         <= 1'b0;
      power_off_request      <= 1'b0;
      defaults_reloaded      <= 1'b0;
      scaling_port_addr      <= `SCALING_ADDR_BASE;
      general_port_addr      <= `GENERAL_ADDR_BASE;
      buck_port_select       <= 4'h0;
      sleep_plan             <= '0;
    end else begin
      sequence_slot_duration <= slot_sel;
      long_press_irq         <= lp_warn;
      power_off_request      <= lp_off;
      defaults_reloaded      <= lp_reload | off_reload;
      scaling_port_addr      <= scaling_addr_w;
      general_port_addr      <= general_addr_w;
      // 0: general port, 1: scaling port
      buck_port_select       <= serial_cfg_r[3:0];
      sleep_plan.regulator_sleep_active <= reg_keep_w;
      sleep_plan.buck_sleep_active      <= buck_keep_w;
      sleep_plan.buck_sleep_low_power   <= buck_low_w;
    end
  end

endmodule : pmu_device_config_regs

/* File: bench/pmu_cfg_properties.sv */
// port-level assertions for the configuration register bank
`timescale 1ns/100ps
module pmu_cfg_properties #(
  parameter logic [31:0] LP_WARN_CYCLES  = 32'd40,
  parameter logic [31:0] LP_EXTRA_CYCLES = 32'd10
) (
  input wire logic                  ref_clk,
  input wire logic                  nrst,
  input wire pmu_cfg_pkg::reg_req_t reg_req,
  input wire pmu_cfg_pkg::reg_rsp_t reg_rsp,
  input wire logic                  irq_pending,
  input wire logic                  power_button_n,
  input wire logic                  off_state_entry,
  input wire logic                  keep_contents_in_off_n,
  input wire logic                  sleep_request,
  input wire pmu_cfg_pkg::pad_t     irq_out_pin,
  input wire logic                  slot_tick,
  input wire logic                  long_press_irq,
  input wire logic                  power_off_request,
  input wire logic                  defaults_reloaded,
  input wire logic [6:0]            scaling_port_addr,
  input wire logic [6:0]            general_port_addr
);
  import pmu_cfg_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [31:0] low_cnt_r;
  // run length of the pressed button; cleared at once on release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt_r <= 32'h0;
    end else begin
      low_cnt_r <= power_button_n ? 32'h0 : low_cnt_r + 32'h1;
    end
  end
  AST_SLEEP_BLOCKED:
    assert property (sleep_request |-> !$past(irq_pending))
    else $error("sleep requested with interrupt pending");
  AST_PAD_RELEASE:
    assert property ($rose(irq_out_pin.oe_n) |-> irq_out_pin.out)
    else $error("pad released while level low");
  AST_SLOT_SPACING:
    assert property (slot_tick |=> !slot_tick [*4])
    else $error("slot ticks too close");
  AST_WARN_HELD:
    assert property (long_press_irq |-> low_cnt_r >= LP_WARN_CYCLES
      && low_cnt_r <= LP_WARN_CYCLES + 32'd3)
    else $error("long press warning at wrong time");
  AST_OFF_AFTER_WARN:
    assert property (power_off_request
      |-> $past(long_press_irq, LP_EXTRA_CYCLES))
    else $error("power off not one extra span after warning");
  AST_OFF_BUTTON:
    assert property (power_off_request
      |-> !power_button_n && $past(!power_button_n))
    else $error("power off without held button");
  AST_RELOAD_CAUSE:
    assert property (defaults_reloaded |-> power_off_request
      || $past(off_state_entry && !keep_contents_in_off_n))
    else $error("reload without cause");
  AST_SCALING_ADDR:
    assert property (scaling_port_addr inside {[7'h12:7'h15]})
    else $error("scaling address out of range");
  AST_GENERAL_ADDR:
    assert property (general_port_addr inside {[7'h2d:7'h30]})
    else $error("general address out of range");
  AST_UNMAPPED_ZERO:
    assert property (reg_rsp.valid
      && !($past(reg_req.addr) inside {[8'h25:8'h28]})
      |-> reg_rsp.rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : pmu_cfg_properties

bind pmu_device_config_regs pmu_cfg_properties #(
  .LP_WARN_CYCLES (LP_WARN_CYCLES),
  .LP_EXTRA_CYCLES(LP_EXTRA_CYCLES)
) u_props (.ref_clk, .nrst, .reg_req, .reg_rsp, .irq_pending, .power_button_n,
  .off_state_entry, .keep_contents_in_off_n, .sleep_request, .irq_out_pin,
  .slot_tick, .long_press_irq, .power_off_request, .defaults_reloaded,
  .scaling_port_addr, .general_port_addr);

/* File: bench/host_model.sv */
// host processor model issuing single-byte register accesses
`timescale 1ns/100ps
`include "pmu_cfg_params.svh"
module host_model #(
  parameter bit STRAP_GROUNDED = 1'b0
) (
  input  wire logic                  ref_clk,
  output pmu_cfg_pkg::reg_req_t      reg_req,
  input  wire pmu_cfg_pkg::reg_rsp_t reg_rsp
);
  import pmu_cfg_pkg::*;
  initial reg_req = '0;
  // strobe for one edge; idle address and data show inverted junk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (STRAP_GROUNDED && a == `OFS_DEVICE_CONTROL_TWO) ? d & 8'h7f : d;
    @(posedge ref_clk);
    reg_req <= '{1'b1, 1'b0, a, v};
    @(posedge ref_clk);
    reg_req <= '{1'b0, 1'b0, ~a, ~v};
  endtask : wr
  // answer is taken in the cycle after the strobe edge only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    reg_req <= '{1'b0, 1'b0, ~a, 8'hff};
    #1;
    d = (reg_rsp.valid === 1'b1) ? reg_rsp.rdata : 8'hxx;
  endtask : rd
endmodule : host_model

/* File: bench/pmu_device_config_regs_tb.sv */
// self-checking bench of the configuration register bank
`timescale 1ns/100ps
`include "pmu_cfg_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module pmu_device_config_regs_tb;
  import pmu_cfg_pkg::*;
  localparam logic [31:0] LPW = 32'd40;
  localparam logic [31:0] LPX = 32'd10;
  localparam int SLOT [4] = '{5, 7, 9, 11};
  localparam otp_defaults_t OTP = '{8'hff, 8'h9c, 8'ha5, 8'hff};
  logic ref_clk = 1'b0, nrst = 1'b0, sleep_pin = 1'b0, irq_pending = 1'b0;
  logic irq_request = 1'b0, power_button_n = 1'b1, off_state_entry = 1'b0;
  logic keep_contents_in_off_n = 1'b1, sleep_request, slot_tick;
  logic long_press_irq, power_off_request, defaults_reloaded;
  logic [3:0] buck_forced_mode = 4'h2, buck_port_select;
  logic [1:0] sequence_slot_duration;
  logic [6:0] scaling_port_addr, general_port_addr;
  reg_req_t reg_req;
  reg_rsp_t reg_rsp;
  pad_t irq_out_pin;
  sleep_plan_t sleep_plan;
  int errors = 0, comparisons = 0;
  initial forever #2 ref_clk = ~ref_clk;
  host_model u_host (.ref_clk, .reg_req, .reg_rsp);
  pmu_device_config_regs #(
    .SLOT0_CYCLES(32'(SLOT[0])), .SLOT1_CYCLES(32'(SLOT[1])),
    .SLOT2_CYCLES(32'(SLOT[2])), .SLOT3_CYCLES(32'(SLOT[3])),
    .LP_WARN_CYCLES(LPW), .LP_EXTRA_CYCLES(LPX)
  ) u_dut (.ref_clk, .nrst, .reg_req, .reg_rsp, .otp_defaults(OTP), .sleep_pin,
    .irq_pending, .irq_request, .power_button_n, .off_state_entry,
    .keep_contents_in_off_n, .buck_forced_mode, .sleep_request, .irq_out_pin,
    .sequence_slot_duration, .slot_tick, .long_press_irq, .power_off_request,
    .defaults_reloaded, .scaling_port_addr, .general_port_addr,
    .buck_port_select, .sleep_plan);
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] v;
    u_host.rd(8'h25, v); `CHK(v, OTP.device_control_two & 8'h77)
    u_host.rd(8'h26, v); `CHK(v, OTP.serial_port_config)
    u_host.rd(8'h28, v); `CHK(v, OTP.sleep_keep_active_two & 8'h3f)
    `CHK(scaling_port_addr, 7'h14)
    `CHK(general_port_addr, 7'h2e)
    u_host.wr(8'h26, 8'hf5);
    u_host.wr(8'h28, 8'hd5);
    u_host.wr(8'h27, 8'h5a);
    u_host.wr(8'h30, 8'hff);
    u_host.rd(8'h26, v); `CHK(v, 8'h95)
    u_host.rd(8'h28, v); `CHK(v, 8'h15)
    u_host.rd(8'h30, v); `CHK(v, 8'h00)
    `CHK(buck_port_select, 4'h5)
    `CHK(sleep_plan.regulator_sleep_active, 10'h15a)
    `CHK(sleep_plan.buck_sleep_active, 4'h5)
    `CHK(sleep_plan.buck_sleep_low_power, 4'h8)
    $display("t_regs done");
  endtask : t_regs
  task automatic t_sleep_pad();
    for (int i = 0; i < 16; i++) begin
      u_host.wr(8'h25, {i[3], i[2], 2'b00, i[1] ^ i[2], 2'b00, i[1]});
      @(posedge ref_clk);
      sleep_pin <= i[1];
      irq_pending <= i[0];
      irq_request <= i[0];
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK(sleep_request, i[3] & ~i[0] & i[2])
      `CHK(irq_out_pin.out, i[1] ~^ i[0])
      `CHK(irq_out_pin.oe_n, i[2] ? 1'b0 : i[1] ~^ i[0])
    end
    $display("t_sleep_pad done");
  endtask : t_sleep_pad
  task automatic wait_tick(output int n);
    n = 0;
    do begin @(posedge ref_clk); #1; n++; end
    while (slot_tick !== 1'b1 && n < 100);
  endtask : wait_tick
  task automatic t_slot();
    int n;
    for (int c = 0; c < 4; c++) begin
      u_host.wr(8'h25, {2'b00, c[1:0], 4'h0});
      repeat (2) wait_tick(n);
      wait_tick(n);
      `CHK(n, SLOT[c])
      `CHK(sequence_slot_duration, c[1:0])
    end
    $display("t_slot done");
  endtask : t_slot
  task automatic t_lp(input logic [7:0] ctrl, input logic reload);
    int n;
    logic [7:0] v;
    u_host.wr(8'h27, 8'h00);
    u_host.wr(8'h25, ctrl);
    @(posedge ref_clk);
    power_button_n <= 1'b0;
    n = 0;
    while (long_press_irq !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(n >= LPW && n <= LPW + 3, 1'b1)
    n = 0;
    while (power_off_request !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(n, LPX)
    `CHK(defaults_reloaded, reload)
    @(posedge ref_clk);
    power_button_n <= 1'b1;
    u_host.rd(8'h27, v);
    `CHK(v, reload ? OTP.sleep_keep_active_one : 8'h00)
    $display("t_lp done");
  endtask : t_lp
  task automatic t_off();
    logic [7:0] v;
    for (int k = 1; k >= 0; k--) begin
      u_host.wr(8'h27, 8'h3c);
      @(posedge ref_clk);
      keep_contents_in_off_n <= k[0];
      off_state_entry <= 1'b1;
      @(posedge ref_clk);
      off_state_entry <= 1'b0;
      keep_contents_in_off_n <= 1'b1;
      u_host.rd(8'h27, v);
      `CHK(v, k[0] ? 8'h3c : OTP.sleep_keep_active_one)
    end
    $display("t_off done");
  endtask : t_off
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // main sequence after an eight-cycle power-on reset
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    t_regs();
    t_sleep_pad();
    t_slot();
    t_lp(8'h06, 1'b1);
    t_lp(8'h04, 1'b0);
    t_off();
    end_sim();
  end
  // watchdog: the whole run needs well under ten thousand cycles
  initial begin
    #100us;
    errors++;
    end_sim();
  end
endmodule : pmu_device_config_regs_tb
